// [verilog/cph_consts.svh]
`ifndef CPH_CONSTS_SVH
`define CPH_CONSTS_SVH

// ---------------------------------------------------------------
// widths
// ---------------------------------------------------------------
`define CPH_RATIO_W 32
`define CPH_ADJ_W 34
`define CPH_LEN_W 34

// ---------------------------------------------------------------
// phase length limits, in source clock periods
// ---------------------------------------------------------------
`define CPH_MIN_PHASE 34'h2
`define CPH_ONE_PHASE 34'h1
`define CPH_MAX_STEP 35'sh1_0000_0000
`define CPH_ADJ_POS_SAT 34'sh1_ffff_ffff
`define CPH_ADJ_NEG_SAT 34'sh2_0000_0000
`define CPH_MIN_COARSE_RATIO 32'h5
`define CPH_MIN_RATIO 32'h2

// ---------------------------------------------------------------
// supply codes for the level check
// ---------------------------------------------------------------
`define CPH_VDD_3V3 3'h0
`define CPH_VDD_2V5 3'h1
`define CPH_VDD_1V8 3'h2

`endif

// [verilog/cph_pkg.sv]
package cph_pkg;
    `include "cph_consts.svh"

    // divider setting: ratio and programmed high width
    typedef struct packed {
        logic [`CPH_RATIO_W-1:0] ratio;
        logic [`CPH_RATIO_W-1:0] duty_high;
    } cph_div_cfg_t;

    // output buffer setting
    typedef struct packed {
        logic diff_mode;
        logic comp_invert;
        logic [1:0] diff_swing_code;
        logic [2:0] common_mode_code;
        logic [1:0] se_impedance_code;
        logic [2:0] output_supply_code;
    } cph_buf_cfg_t;

    typedef enum logic {CPH_HIGH, CPH_LOW} cph_phase_t;
endpackage

// [verilog/cph_len_calc.sv]
`timescale 1ns/1ps
module cph_len_calc (
    input wire logic [31:0] i_ratio,
    input wire logic [31:0] i_duty_high,
    input wire logic i_duty_mode,
    input wire logic signed [33:0] i_adj,
    input wire logic i_apply,
    output logic [33:0] o_high_len,
    output logic [33:0] o_low_len
);
    import cph_pkg::*;

    logic [33:0] base_h;
    logic [33:0] base_l;
    logic signed [34:0] adj_h;
    logic signed [34:0] adj_l;
    logic signed [34:0] half;

    // limit one phase step to the largest allowed change
    function automatic logic signed [34:0] lim_step(
        input logic signed [34:0] a);
        if (a > `CPH_MAX_STEP) begin
            lim_step = `CPH_MAX_STEP; // [RULE4]
        end else if (a < -`CPH_MAX_STEP) begin
            lim_step = -`CPH_MAX_STEP;
        end else begin
            lim_step = a;
        end
    endfunction

    // base plus step, never below the shortest phase
    function automatic logic [33:0] add_phase(input logic [33:0] b,
        input logic signed [34:0] a);
        logic signed [35:0] s;
        s = $signed({2'b00, b}) + 36'(a);
        if (s < $signed({2'b00, `CPH_MIN_PHASE})) begin
            add_phase = `CPH_MIN_PHASE; // [RULE2]
        end else begin
            add_phase = s[33:0];
        end
    endfunction

    // base lengths: programmed high width or an even split
    always_comb begin
        if (i_ratio < `CPH_MIN_RATIO) begin
            base_h = `CPH_ONE_PHASE;
            base_l = `CPH_ONE_PHASE;
        end else if (i_duty_mode) begin
            base_h = {2'b00, i_duty_high};
            base_l = {2'b00, i_ratio - i_duty_high};
        end else begin
            base_h = {3'b000, i_ratio[31:1]};
            base_l = {2'b00, i_ratio - {1'b0, i_ratio[31:1]}};
        end
    end

    // share the step between the phases, or put all of it on low in duty mode
    always_comb begin
        half = 35'(i_adj) >>> 1;
        if (i_duty_mode) begin
            adj_h = '0;
            adj_l = lim_step(35'(i_adj));
        end else begin
            adj_h = lim_step(half);
            adj_l = lim_step(35'(i_adj) - half);
        end
        // a programmed high width is never touched, not even by the clamp
        if (i_apply && !i_duty_mode) begin
            o_high_len = add_phase(base_h, adj_h); // [RULE6]
        end else begin
            o_high_len = base_h; // [RULE7]
        end
        if (i_apply) begin
            o_low_len = add_phase(base_l, adj_l);
        end else begin
            o_low_len = base_l;
        end
    end
endmodule

// [verilog/cph_out_buf.sv]
`timescale 1ns/1ps
module cph_out_buf (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_clk_level,
    input wire cph_pkg::cph_buf_cfg_t i_cfg,
    output logic o_true_output_pin,
    output logic o_complement_output_pin,
    output cph_pkg::cph_buf_cfg_t o_cfg,
    output logic o_level_cfg_err
);
    import cph_pkg::*;

    // highest crossing level code allowed for supply and swing
    function automatic logic [3:0] max_cm(input logic [2:0] vdd,
        input logic [1:0] sw);
        case (vdd)
            `CPH_VDD_3V3: max_cm = (sw[1]) ? (sw[0] ? 4'h5 : 4'h6)
                                           : 4'h7;
            `CPH_VDD_2V5: max_cm = (sw == 2'h0) ? 4'h4
                                 : (sw == 2'h3) ? 4'h2 : 4'h3;
            `CPH_VDD_1V8: max_cm = (sw[1]) ? 4'h0
                                 : (sw[0] ? 4'h1 : 4'h2);
            default: max_cm = 4'hf;
        endcase
    endfunction

    // pin drive: complementary pair, or two single ended copies unless comp_invert inverts the complement pin
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_true_output_pin <= 1'b0;
            o_complement_output_pin <= 1'b0;
        end else begin
            o_true_output_pin <= i_clk_level; // [RULE10]
            if (i_cfg.diff_mode || i_cfg.comp_invert) begin
                o_complement_output_pin <= ~i_clk_level; // [RULE12]
            end else begin
                o_complement_output_pin <= i_clk_level; // [RULE11]
            end
        end
    end

    // registered level, swing and impedance codes to the pads
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_cfg <= '0;
            o_level_cfg_err <= 1'b0;
        end else begin
            o_cfg <= i_cfg; // [RULE13] [RULE14] [RULE15]
            // a crossing level out of reach, or an undefined supply code in diff
            o_level_cfg_err <= i_cfg.diff_mode &&
                ({1'b0, i_cfg.common_mode_code} >
                 max_cm(i_cfg.output_supply_code,
                        i_cfg.diff_swing_code)
                 || i_cfg.output_supply_code > `CPH_VDD_1V8); // [RULE14]
        end
    end
endmodule

// [verilog/cph_coarse_phase.sv]
`timescale 1ns/1ps

// Operation
// (RULE1) coarse shift moves output edges in whole source clock periods
// (RULE2) shortened phases never go below two source periods each
// (RULE3) ratios one to four refuse coarse shifts; use fine adjust
// (RULE4) one request changes each phase by at most 2^32 periods
// (RULE5) positive value lengthens, negative shortens, all in one period
// (RULE6) even duty output splits the change over high and low
// (RULE7) programmed duty output puts the whole change on low phase
// (RULE8) any number of successive requests accepted and applied
// (RULE9) software should split large shifts into smaller steps
// (RULE10) buffer runs as one differential or two single ended pins
// (RULE11) single ended pins carry identical copies of one clock
// (RULE12) a setting inverts the complement pin in single ended mode
// (RULE13) two bit swing code picks one of four differential swings
// (RULE14) three bit code picks one of eight crossing levels
// (RULE15) single ended mode offers four drive impedance choices
// (RULE16) output clock is source clock divided by 32-bit ratio; ratios 0 and 1 give a period of two source cycles
// (RULE17) output is even duty unless a high width is programmed
// (RULE18) programmed high width counts source cycles, below ratio
// (RULE19) each request is one shot, applied at next period start
module cph_coarse_phase (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire cph_pkg::cph_div_cfg_t i_div_cfg,
    input wire cph_pkg::cph_buf_cfg_t i_buf_cfg,
    input wire logic signed [33:0] i_coarse_phase_shift_value,
    input wire logic i_adj_wr,
    output logic o_true_output_pin,
    output logic o_complement_output_pin,
    output cph_pkg::cph_buf_cfg_t o_buf_cfg,
    output logic o_level_cfg_err,
    output logic o_adj_pending,
    output logic o_adj_refused,
    output logic o_adj_done,
    output logic o_period_start
);
    import cph_pkg::*;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    cph_phase_t phase_q;
    logic [33:0] cnt_q;
    logic [33:0] low_len_q;
    logic [33:0] high_len_q;
    logic [33:0] calc_high;
    logic [33:0] calc_low;
    logic signed [33:0] adj_q;
    logic signed [33:0] adj_d;
    logic signed [34:0] adj_sum;
    logic boundary;
    logic high_end;
    logic duty_mode;
    logic coarse_ok;
    logic wr_ok;

    // ---------------------------------------------------------------
    // setting decode
    // ---------------------------------------------------------------

    // programmed width used only when nonzero and below the ratio
    assign duty_mode = (i_div_cfg.duty_high != '0) &&
        (i_div_cfg.duty_high < i_div_cfg.ratio); // [RULE17] [RULE18]
    // coarse shifts need at least two periods in each phase
    assign coarse_ok = i_div_cfg.ratio >= `CPH_MIN_COARSE_RATIO; // [RULE3]
    assign wr_ok = i_adj_wr && coarse_ok;
    // last cycle of the low phase closes the output period
    assign boundary = (phase_q == CPH_LOW) && (cnt_q <= `CPH_ONE_PHASE);
    assign high_end = (phase_q == CPH_HIGH) && (cnt_q <= `CPH_ONE_PHASE);

    // ---------------------------------------------------------------
    // pending request
    // ---------------------------------------------------------------

    // a write while a request waits adds to it, saturating
    always_comb begin
        adj_sum = 35'(adj_q) + 35'(i_coarse_phase_shift_value);
        if (o_adj_pending && !boundary) begin
            if (adj_sum > 35'(`CPH_ADJ_POS_SAT)) begin
                adj_d = `CPH_ADJ_POS_SAT; // [RULE8]
            end else if (adj_sum < 35'(`CPH_ADJ_NEG_SAT)) begin
                adj_d = `CPH_ADJ_NEG_SAT;
            end else begin
                adj_d = adj_sum[33:0];
            end
        end else begin
            adj_d = i_coarse_phase_shift_value;
        end
    end

    // request latch: a new write wins over consumption
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            adj_q <= '0;
            o_adj_pending <= 1'b0;
        end else if (wr_ok) begin
            adj_q <= adj_d; // [RULE8]
            o_adj_pending <= 1'b1;
        end else if (boundary || !coarse_ok) begin
            adj_q <= '0;
            o_adj_pending <= 1'b0; // [RULE19]
        end
    end

    // request outcome strobes
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_adj_refused <= 1'b0;
            o_adj_done <= 1'b0;
        end else begin
            o_adj_refused <= i_adj_wr && !coarse_ok; // [RULE3]
            o_adj_done <= boundary && o_adj_pending && coarse_ok;
        end
    end

    // ---------------------------------------------------------------
    // next period lengths
    // ---------------------------------------------------------------

    // base split plus the pending shift, clamped per phase
    cph_len_calc u_calc (
        .i_ratio(i_div_cfg.ratio),
        .i_duty_high(i_div_cfg.duty_high),
        .i_duty_mode(duty_mode),
        .i_adj(adj_q),
        .i_apply(o_adj_pending && coarse_ok), // [RULE1] [RULE5]
        .o_high_len(calc_high),
        .o_low_len(calc_low)
    );

    // ---------------------------------------------------------------
    // integer divider with phase counter
    // ---------------------------------------------------------------

    // high then low phase, lengths frozen at each period start
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            phase_q <= CPH_LOW;
            cnt_q <= `CPH_ONE_PHASE;
            high_len_q <= `CPH_ONE_PHASE;
            low_len_q <= `CPH_ONE_PHASE;
        end else if (boundary) begin
            phase_q <= CPH_HIGH; // [RULE16]
            cnt_q <= calc_high; // [RULE6] [RULE7]
            high_len_q <= calc_high;
            low_len_q <= calc_low; // [RULE5]
        end else if (high_end) begin
            phase_q <= CPH_LOW;
            cnt_q <= low_len_q;
        end else begin
            cnt_q <= cnt_q - `CPH_ONE_PHASE;
        end
    end

    // period start strobe
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_period_start <= 1'b0;
        end else begin
            o_period_start <= boundary;
        end
    end

    // ---------------------------------------------------------------
    // output buffer
    // ---------------------------------------------------------------

    // pin drive and pad codes
    cph_out_buf u_buf (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_clk_level(phase_q == CPH_HIGH),
        .i_cfg(i_buf_cfg),
        .o_true_output_pin(o_true_output_pin),
        .o_complement_output_pin(o_complement_output_pin),
        .o_cfg(o_buf_cfg),
        .o_level_cfg_err(o_level_cfg_err)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    logic [33:0] run_q;
    logic signed [35:0] base_tot;
    logic signed [35:0] new_tot;

    // length of the current high run, for the width checks
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            run_q <= '0;
        end else if (phase_q == CPH_HIGH) begin
            run_q <= run_q + `CPH_ONE_PHASE;
        end else begin
            run_q <= '0;
        end
    end

    assign base_tot = 36'(i_div_cfg.ratio);
    assign new_tot = 36'(calc_high) + 36'(calc_low);

    property p_consume;
        boundary && o_adj_pending && !i_adj_wr |=> !o_adj_pending;
    endproperty
    a_consume: assert property (p_consume) // [RULE19]
        else $error("pending shift not consumed at period start");

    property p_refuse;
        i_adj_wr && !coarse_ok && !o_adj_pending
            |=> o_adj_refused && !o_adj_pending;
    endproperty
    a_refuse: assert property (p_refuse) // [RULE3]
        else $error("shift accepted at a small ratio");

    property p_min_phase;
        boundary && coarse_ok && (o_adj_pending || !duty_mode)
            |-> calc_low >= `CPH_MIN_PHASE
                && (duty_mode || calc_high >= `CPH_MIN_PHASE);
    endproperty
    a_min_phase: assert property (p_min_phase) // [RULE2]
        else $error("phase shorter than two source periods");

    property p_high_run;
        phase_q == CPH_HIGH && high_end |-> run_q + 34'h1 == high_len_q;
    endproperty
    a_high_run: assert property (p_high_run) // [RULE16]
        else $error("high run differs from its planned length");

    property p_sign;
        boundary && o_adj_pending && coarse_ok && !duty_mode
            && adj_q > 0 |-> new_tot > base_tot;
    endproperty
    a_sign: assert property (p_sign) // [RULE5]
        else $error("positive shift did not lengthen the period");

    property p_step_max;
        boundary && coarse_ok && !duty_mode && i_div_cfg.ratio[0] == 1'b0
            |-> new_tot <= base_tot + 36'sh2_0000_0000;
    endproperty
    a_step_max: assert property (p_step_max) // [RULE4]
        else $error("period grew by more than the largest step");

    property p_split;
        boundary && coarse_ok && !duty_mode && !i_div_cfg.ratio[0]
            && adj_q >= 0 && adj_q < 34'sh1000
            |-> calc_low - calc_high <= 34'h1;
    endproperty
    a_split: assert property (p_split) // [RULE6]
        else $error("even duty shift not split over both phases");

    property p_duty_high;
        boundary && duty_mode |-> calc_high == {2'b00,
            i_div_cfg.duty_high};
    endproperty
    a_duty_high: assert property (p_duty_high) // [RULE7]
        else $error("programmed high width was changed by a shift");

    property p_se_copy;
        !i_buf_cfg.diff_mode && !i_buf_cfg.comp_invert
            |=> o_true_output_pin == o_complement_output_pin;
    endproperty
    a_se_copy: assert property (p_se_copy) // [RULE11]
        else $error("single ended copies differ");

    property p_inv;
        i_buf_cfg.comp_invert |=> o_true_output_pin
            != o_complement_output_pin;
    endproperty
    a_inv: assert property (p_inv) // [RULE12]
        else $error("complement pin not inverted");

    property p_done;
        boundary && o_adj_pending && coarse_ok |=> o_adj_done;
    endproperty
    a_done: assert property (p_done) // [RULE19]
        else $error("applied shift not reported as done");

    property p_pin_rise;
        o_period_start |=> o_true_output_pin;
    endproperty
    a_pin_rise: assert property (p_pin_rise) // [RULE16]
        else $error("true pin did not rise after period start");

    property p_plain_len;
        boundary && coarse_ok && !o_adj_pending && !duty_mode
            |-> new_tot == base_tot && calc_low - calc_high <= 34'h1;
    endproperty
    a_plain_len: assert property (p_plain_len) // [RULE17]
        else $error("unshifted period is not an even split of ratio");

    property p_se_err;
        !i_buf_cfg.diff_mode |=> !o_level_cfg_err;
    endproperty
    a_se_err: assert property (p_se_err) // [RULE14]
        else $error("level error flagged in single ended mode");

    c_done: cover property (o_adj_done ##1 o_period_start[*2]);
    c_refused: cover property (o_adj_refused);
    c_back: cover property (wr_ok ##1 wr_ok ##[1:50] o_adj_done);
    c_neg: cover property (boundary && o_adj_pending && adj_q < 0);
endmodule

// [sim/cph_rx_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// receiver model: times each level of the received clock
// ---------------------------------------------------------------
module cph_rx_model (
    input wire logic i_mclk,
    input wire logic i_pin,
    output logic [35:0] o_high_len,
    output logic [35:0] o_low_len,
    output logic [31:0] o_edges
);
    logic pin_q;
    logic [35:0] cnt_q;

    initial o_edges = 32'h0;

    // count source cycles per level, latch the length at each change
    always @(posedge i_mclk) begin
        pin_q <= i_pin;
        if (i_pin !== pin_q) begin
            cnt_q <= 36'h1;
            if (i_pin === 1'b1) begin
                o_low_len <= cnt_q;
                o_edges <= o_edges + 32'h1;
            end else begin
                o_high_len <= cnt_q;
            end
        end else begin
            cnt_q <= cnt_q + 36'h1;
        end
    end
endmodule

// [sim/output_coarse_phase_adjust_test.sv]
`timescale 1ns/1ps
module output_coarse_phase_adjust_test;
    import cph_pkg::*;
    typedef struct {
        logic [31:0] ratio;
        logic [31:0] duty;
        logic signed [33:0] adj;
        logic [35:0] eh;
        logic [35:0] el;
        logic [35:0] bh;
        logic [35:0] bl;
    } cph_row_t;
    logic clk, rst_n, wr, tru, cmp, pend, refu, done, pst, lerr;
    cph_div_cfg_t div;
    cph_buf_cfg_t bcfg, ocfg;
    logic signed [33:0] adj;
    logic [35:0] hi, lo;
    logic [31:0] edges;
    int err_count = 0;
    int checked = 0;
    // ratio, duty, shift, shifted high/low, plain high/low
    cph_row_t rows [9] = '{
        '{32'h6, 32'h0, 34'sh2, 36'h4, 36'h4, 36'h3, 36'h3},
        '{32'h7, 32'h0, 34'sh3, 36'h4, 36'h6, 36'h3, 36'h4},
        '{32'h8, 32'h0, -34'sh4, 36'h2, 36'h2, 36'h4, 36'h4},
        '{32'h8, 32'h0, 34'sh2_0000_0000, 36'h2, 36'h2, 36'h4, 36'h4},
        '{32'ha, 32'h3, 34'sh5, 36'h3, 36'hc, 36'h3, 36'h7},
        '{32'ha, 32'h3, -34'sh14, 36'h3, 36'h2, 36'h3, 36'h7},
        '{32'h5, 32'h0, -34'sh1, 36'h2, 36'h3, 36'h2, 36'h3},
        '{32'h6, 32'h6, 34'sh2, 36'h4, 36'h4, 36'h3, 36'h3},
        '{32'h6, 32'h1, 34'sh2, 36'h1, 36'h7, 36'h1, 36'h5}};
    // buffer setting, level error, complement inverted
    logic [13:0] bufs [8] = '{{12'h9e0, 2'b01}, {12'hbc8, 2'b11},
        {12'hc81, 2'b01}, {12'ha22, 2'b11}, {12'h803, 2'b11},
        {12'h414, 2'b01}, {12'h2f8, 2'b00}, {12'hae0, 2'b11}};

    cph_coarse_phase cph_coarse_phase_i (
        .i_mclk(clk),
        .i_rst_n(rst_n),
        .i_div_cfg(div),
        .i_buf_cfg(bcfg),
        .i_coarse_phase_shift_value(adj),
        .i_adj_wr(wr),
        .o_true_output_pin(tru),
        .o_complement_output_pin(cmp),
        .o_buf_cfg(ocfg),
        .o_level_cfg_err(lerr),
        .o_adj_pending(pend),
        .o_adj_refused(refu),
        .o_adj_done(done),
        .o_period_start(pst)
    );

    cph_rx_model cph_rx_model_i (
        .i_mclk(clk),
        .i_pin(tru),
        .o_high_len(hi),
        .o_low_len(lo),
        .o_edges(edges)
    );

    // 20 MHz source clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (checked > 0 && err_count == 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, mismatches %0d", name, err_count);
    endtask

    // bounded wait for n more rising edges seen by the receiver
    task automatic wait_edges(input int n);
        int e0;
        int k;
        e0 = edges;
        k = 0;
        while (edges < e0 + n && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk(36'(k >= 1000), 36'h0);
    endtask

    // bounded wait for a one cycle flag
    task automatic wait_flag(input bit sel_done);
        int k;
        k = 0;
        while ((sel_done ? done : pst) !== 1'b1 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        chk(36'(k >= 1000), 36'h0);
    endtask

    // one write pulse, returns at the negedge after it is taken
    task automatic wr_adj(input logic signed [33:0] v);
        adj = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #2000000;
        err_count++;
        test_done;
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        div = '{ratio: 32'h6, duty_high: 32'h0};
        bcfg = cph_buf_cfg_t'(12'h9e0);
        adj = '0;
        wr = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[n]) begin
            div.ratio = rows[n].ratio;
            div.duty_high = rows[n].duty; // zero, below ratio, or equal to ratio
            wait_edges(3);
            wait_flag(1'b0);
            wr_adj(rows[n].adj);
            chk(36'(pend), 36'h1);
            wait_flag(1'b1);
            wait_edges(2);
            chk(hi, rows[n].eh);
            chk(lo, rows[n].el);
            wait_edges(1);
            chk(hi, rows[n].bh);
            chk(lo, rows[n].bl);
            end_test("shift row");
        end
        // small ratios refuse every shift
        for (int r = 1; r <= 4; r++) begin
            div = '{ratio: 32'(r), duty_high: 32'h0};
            repeat (4) @(negedge clk);
            wr_adj(34'sh3);
            chk(36'({refu, pend}), 36'h2);
        end
        end_test("refusal");
        // a pending shift is dropped when the ratio falls below five
        div.ratio = 32'h64;
        wait_edges(2);
        wait_flag(1'b0);
        wr_adj(34'sh2);
        div.ratio = 32'h4;
        repeat (2) @(negedge clk);
        chk(36'(pend), 36'h0);
        end_test("drop");
        // two writes while pending add up and are applied together in one period
        div.ratio = 32'h8;
        wait_edges(3);
        wait_flag(1'b0);
        wr_adj(34'sh2);
        @(negedge clk);
        wr_adj(34'sh2);
        wait_flag(1'b1);
        wait_edges(2);
        chk(hi, 36'h6);
        chk(lo, 36'h6);
        end_test("accumulate");
        // buffer modes, level codes and complement pin
        foreach (bufs[n]) begin
            bcfg = cph_buf_cfg_t'(bufs[n][13:2]);
            wait_edges(2);
            chk(36'(ocfg), 36'(bufs[n][13:2]));
            chk(36'(lerr), 36'(bufs[n][1]));
            repeat (12) begin
                @(negedge clk);
                chk(36'(cmp), 36'(tru ^ bufs[n][0]));
            end
        end
        end_test("buffer");
        // reset in mid run clears a waiting shift
        div.ratio = 32'h64;
        wait_edges(2);
        wait_flag(1'b0);
        wr_adj(34'sh2);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        chk(36'({tru, cmp, pend, refu, done, pst, ocfg}), 36'h0);
        rst_n = 1'b1;
        wait_flag(1'b0);
        @(negedge clk);
        chk(36'({tru, pend}), 36'h2);
        end_test("reset");
        test_done;
    end
endmodule
